// *** design/pcs_rx_mon_pkg.sv ***
package pcs_rx_mon_pkg;
  // ************************************************************
  // Lane geometry
  // ************************************************************
  localparam int NUM_LANES = 4;
  localparam int LANE_GBPS = 10;
  localparam int LANE_W    = 64;
  localparam int TAG_W     = 2;
  localparam int BIP_W     = 8;
  localparam int FLAG_W    = 16;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [11:0] ADDR_CLK_LOCK   = 12'h321;
  localparam logic [11:0] ADDR_FRAME_ERR  = 12'h323;
  localparam logic [11:0] ADDR_FRM_CLR    = 12'h324;
  localparam logic [11:0] ADDR_ALIGN      = 12'h326;
  localparam logic [11:0] ADDR_FLAG_SEL   = 12'h327;
  localparam logic [11:0] ADDR_FLAG_VIEW  = 12'h328;
  localparam logic [11:0] ADDR_CONFIG     = 12'h329;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h32a;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h32b;
  localparam logic [11:0] ADDR_IRQ_CLEAR  = 12'h32c;
  localparam int FLAG_SEL_W = 2;
  localparam int CFG_FAULT_EN = 0;
  localparam int ALIGN_BIT    = 0;
  localparam int CLR_BIT      = 0;
  // ************************************************************
  // Interrupt bits
  // ************************************************************
  localparam int IRQ_W   = 5;
  localparam int IRQ_LOS = 0;
  localparam int IRQ_FRM = 1;
  localparam int IRQ_FCS = 2;
  localparam int IRQ_DEC = 3;
  localparam int IRQ_BIP = 4;
  // ************************************************************
  // Word lock and timing
  // ************************************************************
  localparam logic [6:0] LOCK_GOOD_CNT = 7'h40;
  localparam logic [6:0] LOCK_WIN_CNT  = 7'h40;
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int RX_RESET_NS    = 100;
  localparam int RX_RESET_CYC   = (RX_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] RX_RESET_CYCLES = 8'(RX_RESET_CYC);
  // ************************************************************
  // Frame check
  // ************************************************************
  localparam logic [31:0] CRC_POLY    = 32'hedb88320;
  localparam logic [31:0] CRC_INIT    = 32'hffffffff;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
  typedef enum logic [1:0] {LANE_HUNT = 2'b01, LANE_LOCKED = 2'b10} word_lock_state_t;
  typedef enum logic [2:0] {
    LINK_DOWN  = 3'b001,
    LINK_UP    = 3'b010,
    LINK_RESET = 3'b100
  } link_state_t;
endpackage

// *** design/pcs_rx_link_health_monitor.sv ***
`timescale 1ns/10ps
module pcs_rx_link_health_monitor
  import pcs_rx_mon_pkg::*;
(
  input  logic                                                  sys_clk,
  input  logic                                                  reset_n,
  input  logic [pcs_rx_mon_pkg::ADDR_W-1:0]                     reg_addr,
  input  logic [pcs_rx_mon_pkg::DATA_W-1:0]                     reg_wr_data,
  input  logic                                                  reg_wr,
  input  logic                                                  reg_rd,
  output logic [pcs_rx_mon_pkg::DATA_W-1:0]                     reg_rd_data,
  input  logic [pcs_rx_mon_pkg::NUM_LANES-1:0]                  lane_clock_locked,
  input  logic                                                  signal_detect,
  input  logic                                                  am_lock,
  input  logic [pcs_rx_mon_pkg::NUM_LANES-1:0]                  lane_hdr_strobe,
  input  logic [pcs_rx_mon_pkg::NUM_LANES-1:0]                  lane_hdr_ok,
  input  logic [pcs_rx_mon_pkg::FLAG_W-1:0]                     fifo_flags,
  input  logic [pcs_rx_mon_pkg::NUM_LANES*pcs_rx_mon_pkg::LANE_W-1:0] lane_data,
  input  logic [pcs_rx_mon_pkg::NUM_LANES*pcs_rx_mon_pkg::TAG_W-1:0]  lane_tag,
  input  logic [pcs_rx_mon_pkg::NUM_LANES-1:0]                  lane_am_strobe,
  input  logic [pcs_rx_mon_pkg::NUM_LANES*pcs_rx_mon_pkg::BIP_W-1:0]  lane_bip_rx,
  input  logic [pcs_rx_mon_pkg::NUM_LANES*pcs_rx_mon_pkg::BIP_W-1:0]  lane_bip_calc,
  input  logic [7:0]                                            rx_byte,
  input  logic                                                  rx_byte_valid,
  input  logic                                                  rx_sof,
  input  logic                                                  rx_eof,
  input  logic                                                  ctrl_char_error,
  output logic [pcs_rx_mon_pkg::NUM_LANES*pcs_rx_mon_pkg::LANE_W-1:0] ordered_data,
  output logic                                                  rx_pcs_ready,
  output logic                                                  local_fault_status,
  output logic                                                  rx_digital_reset,
  output logic                                                  fcs_error,
  output logic                                                  mii_decode_error,
  output logic [pcs_rx_mon_pkg::NUM_LANES-1:0]                  bip_error,
  output logic                                                  irq
);
  import pcs_rx_mon_pkg::*;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [NUM_LANES-1:0] clk_lock_meta_reg;
  logic [NUM_LANES-1:0] clk_lock_reg;
  logic                 sig_meta_reg;
  logic                 sig_reg;
  logic                 am_meta_reg;
  logic                 am_reg;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_lock_meta_reg <= '0;
      clk_lock_reg      <= '0;
      sig_meta_reg      <= 1'b0;
      sig_reg           <= 1'b0;
      am_meta_reg       <= 1'b0;
      am_reg            <= 1'b0;
    end else begin
      clk_lock_meta_reg <= lane_clock_locked;
      clk_lock_reg      <= clk_lock_meta_reg;
      sig_meta_reg      <= signal_detect;
      sig_reg           <= sig_meta_reg;
      am_meta_reg       <= am_lock;
      am_reg            <= am_meta_reg;
    end
  end

  // ************************************************************
  // Register storage
  // ************************************************************
  logic [DATA_W-1:0]     frm_clr_reg;
  logic [FLAG_SEL_W-1:0] flag_sel_reg;
  logic                  fault_en_reg;
  logic [IRQ_W-1:0]      irq_enable_reg;
  logic [IRQ_W-1:0]      irq_clear;
  logic [IRQ_W-1:0]      irq_status_reg;
  logic [IRQ_W-1:0]      irq_set;
  logic [NUM_LANES-1:0]  frame_err_reg;
  logic [NUM_LANES-1:0]  frm_set;
  logic                  ready_reg;
  logic                  los;

  assign irq_clear = (reg_wr && reg_addr == ADDR_IRQ_CLEAR) ? reg_wr_data[IRQ_W-1:0] : '0;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      frm_clr_reg    <= '0;
      flag_sel_reg   <= '0;
      fault_en_reg   <= 1'b0;
      irq_enable_reg <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_FRM_CLR:    frm_clr_reg    <= reg_wr_data;
        ADDR_FLAG_SEL:   flag_sel_reg   <= reg_wr_data[FLAG_SEL_W-1:0];
        ADDR_CONFIG:     fault_en_reg   <= reg_wr_data[CFG_FAULT_EN];
        ADDR_IRQ_ENABLE: irq_enable_reg <= reg_wr_data[IRQ_W-1:0];
        default:         ;
      endcase
    end
  end

  // ************************************************************
  // Word lock per lane
  // ************************************************************
  // Lock is lost only on a window of all bad headers, so a locked noisy lane stays locked
  logic [NUM_LANES-1:0] word_locked;

  for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
    word_lock_state_t st_reg;
    logic [6:0]       good_reg;
    logic [6:0]       win_reg;
    logic [6:0]       bad_reg;
    logic             bad_hdr;

    assign bad_hdr        = lane_hdr_strobe[l] & ~lane_hdr_ok[l];
    assign word_locked[l] = (st_reg == LANE_LOCKED);
    assign frm_set[l]     = bad_hdr | ~word_locked[l];

    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        st_reg   <= LANE_HUNT;
        good_reg <= '0;
        win_reg  <= '0;
        bad_reg  <= '0;
      end else if (lane_hdr_strobe[l]) begin
        case (st_reg)
          LANE_HUNT: begin
            win_reg <= '0;
            bad_reg <= '0;
            if (!lane_hdr_ok[l]) begin
              good_reg <= '0;
            end else if (good_reg == LOCK_GOOD_CNT - 7'h01) begin
              good_reg <= '0;
              st_reg   <= LANE_LOCKED;
            end else begin
              good_reg <= good_reg + 7'h01;
            end
          end
          LANE_LOCKED: begin
            if (win_reg == LOCK_WIN_CNT - 7'h01) begin
              win_reg <= '0;
              bad_reg <= '0;
              if (bad_reg + {6'h00, bad_hdr} == LOCK_WIN_CNT) begin
                st_reg <= LANE_HUNT;
              end
            end else begin
              win_reg <= win_reg + 7'h01;
              bad_reg <= bad_reg + {6'h00, bad_hdr};
            end
          end
          default: st_reg <= LANE_HUNT;
        endcase
      end
    end
  end

  // ************************************************************
  // Frame error latch
  // ************************************************************
  // Held clear while the clear bit is one; a new error still wins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_err_reg <= '0;
    end else begin
      frame_err_reg <= frm_set |
        (frame_err_reg & ~{NUM_LANES{frm_clr_reg[CLR_BIT]}});
    end
  end

  // ************************************************************
  // Link state and loss of signal
  // ************************************************************
  link_state_t state_reg;
  logic [7:0]  rst_cnt_reg;
  logic        rx_rst_reg;
  logic        fault_reg;

  assign los = ~sig_reg;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= LINK_DOWN;
      ready_reg   <= 1'b0;
      rst_cnt_reg <= '0;
      rx_rst_reg  <= 1'b0;
    end else begin
      case (state_reg)
        LINK_DOWN: begin
          if (!los && am_reg && (&word_locked)) begin
            state_reg <= LINK_UP;
            ready_reg <= 1'b1;
          end
        end
        LINK_UP: begin
          if (los) begin
            state_reg   <= LINK_RESET;
            ready_reg   <= 1'b0;
            rst_cnt_reg <= RX_RESET_CYCLES;
            rx_rst_reg  <= 1'b1;
          end else if (!am_reg) begin
            state_reg <= LINK_DOWN;
            ready_reg <= 1'b0;
          end
        end
        LINK_RESET: begin
          if (rst_cnt_reg == 8'h01) begin
            state_reg  <= LINK_DOWN;
            rx_rst_reg <= 1'b0;
          end
          rst_cnt_reg <= rst_cnt_reg - 8'h01;
        end
        default: begin
          state_reg  <= LINK_DOWN;
          ready_reg  <= 1'b0;
          rx_rst_reg <= 1'b0;
        end
      endcase
    end
  end

  // No transmit path is touched here; only receive state resets
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= fault_en_reg & los;
    end
  end

  // ************************************************************
  // Frame check and decode errors
  // ************************************************************
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ (CRC_POLY & {32{r[0] ^ b[i]}});
    end
    return r;
  endfunction

  logic [31:0] crc_reg;
  logic [31:0] crc_now;
  logic        fcs_err_reg;
  logic        dec_err_reg;

  assign crc_now = crc_byte(rx_sof ? CRC_INIT : crc_reg, rx_byte);

  // Residue check covers the inverted FCS without a separate compare
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_reg     <= CRC_INIT;
      fcs_err_reg <= 1'b0;
      dec_err_reg <= 1'b0;
    end else begin
      fcs_err_reg <= rx_byte_valid & rx_eof & (crc_now != CRC_RESIDUE);
      dec_err_reg <= ctrl_char_error;
      if (rx_byte_valid) begin
        crc_reg <= crc_now;
      end
    end
  end

  // ************************************************************
  // Lane reorder and marker parity
  // ************************************************************
  logic [NUM_LANES*LANE_W-1:0] ordered_reg;
  logic [NUM_LANES*LANE_W-1:0] ordered_next;
  logic [NUM_LANES-1:0]        bip_err_reg;

  always_comb begin
    ordered_next = '0;
    for (int v = 0; v < NUM_LANES; v++) begin
      for (int p = 0; p < NUM_LANES; p++) begin
        if (lane_tag[p*TAG_W +: TAG_W] == TAG_W'(v)) begin
          ordered_next[v*LANE_W +: LANE_W] = lane_data[p*LANE_W +: LANE_W];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ordered_reg <= '0;
      bip_err_reg <= '0;
    end else begin
      ordered_reg <= ordered_next;
      for (int l = 0; l < NUM_LANES; l++) begin
        bip_err_reg[l] <= lane_am_strobe[l] &
          (lane_bip_rx[l*BIP_W +: BIP_W] != lane_bip_calc[l*BIP_W +: BIP_W]);
      end
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  logic irq_reg;

  always_comb begin
    irq_set          = '0;
    irq_set[IRQ_LOS] = los & (state_reg == LINK_UP);
    irq_set[IRQ_FRM] = |(frm_set & ~frame_err_reg);
    irq_set[IRQ_FCS] = fcs_err_reg;
    irq_set[IRQ_DEC] = dec_err_reg;
    irq_set[IRQ_BIP] = |bip_err_reg;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status_reg <= '0;
      irq_reg        <= 1'b0;
    end else begin
      irq_status_reg <= irq_set | (irq_status_reg & ~irq_clear);
      irq_reg        <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // ************************************************************
  // Register read
  // ************************************************************
  logic [DATA_W-1:0] rd_reg;
  logic [3:0]        flag_view;

  assign flag_view = fifo_flags[flag_sel_reg*4 +: 4];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_reg <= '0;
    end else begin
      rd_reg <= '0;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_CLK_LOCK:   rd_reg <= DATA_W'(clk_lock_reg);
          ADDR_FRAME_ERR:  rd_reg <= DATA_W'(frame_err_reg);
          ADDR_FRM_CLR:    rd_reg <= frm_clr_reg;
          ADDR_ALIGN:      rd_reg <= DATA_W'(ready_reg) << ALIGN_BIT;
          ADDR_FLAG_SEL:   rd_reg <= DATA_W'(flag_sel_reg);
          ADDR_FLAG_VIEW:  rd_reg <= DATA_W'(flag_view);
          ADDR_CONFIG:     rd_reg <= DATA_W'(fault_en_reg);
          ADDR_IRQ_STATUS: rd_reg <= DATA_W'(irq_status_reg);
          ADDR_IRQ_ENABLE: rd_reg <= DATA_W'(irq_enable_reg);
          default:         rd_reg <= '0;
        endcase
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rd_data        = rd_reg;
  assign rx_pcs_ready       = ready_reg;
  assign local_fault_status = fault_reg;
  assign rx_digital_reset   = rx_rst_reg;
  assign fcs_error          = fcs_err_reg;
  assign mii_decode_error   = dec_err_reg;
  assign bip_error          = bip_err_reg;
  assign ordered_data       = ordered_reg;
  assign irq                = irq_reg;
endmodule

// *** tb/pcs_rx_mon_assertions.sv ***
`timescale 1ns/10ps
module pcs_rx_mon_checker
  import pcs_rx_mon_pkg::*;
(
  input logic                       sys_clk,
  input logic                       reset_n,
  input logic [ADDR_W-1:0]          reg_addr,
  input logic                       reg_rd,
  input logic [DATA_W-1:0]          reg_rd_data,
  input logic                       signal_detect,
  input logic                       am_lock,
  input logic                       ctrl_char_error,
  input logic [NUM_LANES-1:0]       lane_am_strobe,
  input logic [NUM_LANES*BIP_W-1:0] lane_bip_rx,
  input logic [NUM_LANES*BIP_W-1:0] lane_bip_calc,
  input logic                       rx_byte_valid,
  input logic                       rx_eof,
  input logic                       rx_pcs_ready,
  input logic                       local_fault_status,
  input logic                       rx_digital_reset,
  input logic                       fcs_error,
  input logic                       mii_decode_error,
  input logic [NUM_LANES-1:0]       bip_error
);
  // ********************
  // Helper logic
  // ********************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [7:0]           rst_len_reg;
  logic [NUM_LANES-1:0] bip_bad;
  // Counter, since twenty cycles is too long for a repetition
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_len_reg <= 8'h00;
    end else begin
      rst_len_reg <= rx_digital_reset ? rst_len_reg + 8'h01 : 8'h00;
    end
  end
  always_comb begin
    for (int l = 0; l < NUM_LANES; l++) begin
      bip_bad[l] = lane_am_strobe[l]
        && (lane_bip_rx[l*BIP_W+:BIP_W] != lane_bip_calc[l*BIP_W+:BIP_W]);
    end
  end
  sequence los_seen;
    $fell(signal_detect) && rx_pcs_ready;
  endsequence
  sequence rx_torn_down;
    !rx_pcs_ready && rx_digital_reset;
  endsequence
  rx_reset_start_a: assert property (los_seen |-> ##[1:4] rx_torn_down)
    else $error("receive reset did not follow signal loss");
  reset_len_a: assert property ($fell(rx_digital_reset) |-> rst_len_reg == RX_RESET_CYC)
    else $error("receive reset length wrong");
  ready_drop_a: assert property ($fell(am_lock) |-> ##[1:4] !rx_pcs_ready)
    else $error("ready kept after marker lock loss");
  aligned_read_a: assert property (reg_rd && reg_addr == ADDR_ALIGN |=>
    reg_rd_data == DATA_W'($past(rx_pcs_ready)))
    else $error("aligned bit differs from ready");
  no_fault_a: assert property (signal_detect [*5] |-> !local_fault_status)
    else $error("local fault with signal present");
  decode_delay_a: assert property (ctrl_char_error |=> mii_decode_error)
    else $error("decode error not reported");
  fcs_timing_a: assert property (fcs_error |-> $past(rx_eof && rx_byte_valid))
    else $error("frame check error outside frame end");
  bip_lane_a: assert property ((|bip_bad) |=> bip_error == $past(bip_bad))
    else $error("parity error on wrong lane");
endmodule
bind pcs_rx_link_health_monitor pcs_rx_mon_checker chk_u (
  .sys_clk, .reset_n, .reg_addr, .reg_rd, .reg_rd_data, .signal_detect, .am_lock,
  .ctrl_char_error, .lane_am_strobe, .lane_bip_rx, .lane_bip_calc, .rx_byte_valid,
  .rx_eof, .rx_pcs_ready, .local_fault_status, .rx_digital_reset, .fcs_error,
  .mii_decode_error, .bip_error
);

// *** tb/lane_link_partner.sv ***
`timescale 1ns/10ps
module lane_link_partner
  import pcs_rx_mon_pkg::*;
(
  input  logic                        sys_clk,
  input  logic                        link_on,
  input  logic                        am_on,
  input  logic [NUM_LANES-1:0]        hdr_bad,
  input  logic [NUM_LANES-1:0]        bip_bad,
  input  logic [NUM_LANES*TAG_W-1:0]  tag_map,
  output logic [NUM_LANES-1:0]        lane_clock_locked,
  output logic                        signal_detect,
  output logic                        am_lock,
  output logic [NUM_LANES-1:0]        lane_hdr_strobe,
  output logic [NUM_LANES-1:0]        lane_hdr_ok,
  output logic [NUM_LANES*LANE_W-1:0] lane_data,
  output logic [NUM_LANES*TAG_W-1:0]  lane_tag,
  output logic [NUM_LANES-1:0]        lane_am_strobe,
  output logic [NUM_LANES*BIP_W-1:0]  lane_bip_rx,
  output logic [NUM_LANES*BIP_W-1:0]  lane_bip_calc
);
  // ********************
  // Remote transmitter
  // ********************
  logic [3:0]       am_cnt_reg = 4'h0;
  logic [BIP_W-1:0] bip_val;
  // Idle lines toggle so no stale value passes for a good header
  always @(posedge sys_clk) begin
    am_cnt_reg <= am_cnt_reg + 4'h1;
    lane_clock_locked <= {NUM_LANES{link_on}};
    signal_detect <= link_on;
    am_lock <= link_on && am_on;
    lane_hdr_strobe <= {NUM_LANES{link_on}};
    lane_hdr_ok <= link_on ? ~hdr_bad : NUM_LANES'($urandom);
    lane_tag <= tag_map;
    lane_am_strobe <= {NUM_LANES{link_on && am_cnt_reg == 4'h0}};
    for (int l = 0; l < NUM_LANES; l++) begin
      bip_val = BIP_W'($urandom);
      lane_data[l*LANE_W+:LANE_W] <= {$urandom, $urandom};
      lane_bip_calc[l*BIP_W+:BIP_W] <= bip_val;
      lane_bip_rx[l*BIP_W+:BIP_W] <= bip_val ^ BIP_W'(bip_bad[l]);
    end
  end
endmodule

// *** tb/test_pcs_rx_link_health_monitor.sv ***
`timescale 1ns/10ps
module test_pcs_rx_link_health_monitor;
  import pcs_rx_mon_pkg::*;
  // ********************
  // Signals and tasks
  // ********************
  logic                        sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [ADDR_W-1:0]           reg_addr = 12'h000;
  logic [DATA_W-1:0]           reg_wr_data = 32'h0, reg_rd_data;
  logic [FLAG_W-1:0]           fifo_flags = 16'h0;
  logic [7:0]                  rx_byte = 8'h00;
  logic                        rx_byte_valid = 1'b0, rx_sof = 1'b0, rx_eof = 1'b0;
  logic                        ctrl_char_error = 1'b0, link_on = 1'b0, am_on = 1'b0;
  logic [NUM_LANES-1:0]        hdr_bad = 4'h0, bip_bad = 4'h0, bip_error;
  logic [NUM_LANES-1:0]        lane_clock_locked, lane_hdr_strobe, lane_hdr_ok, lane_am_strobe;
  logic                        signal_detect, am_lock, rx_pcs_ready, local_fault_status;
  logic                        rx_digital_reset, fcs_error, mii_decode_error, irq;
  logic [NUM_LANES*TAG_W-1:0]  tag_map = 8'he4, lane_tag, snap_tag;
  logic [NUM_LANES*LANE_W-1:0] lane_data, ordered_data, snap_data;
  logic [NUM_LANES*BIP_W-1:0]  lane_bip_rx, lane_bip_calc;
  int                          fail_count = 0, cmp_count = 0, seed_val;
  byte unsigned                byte_q[$];
  pcs_rx_link_health_monitor dut_u (
    .sys_clk, .reset_n, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd, .reg_rd_data,
    .lane_clock_locked, .signal_detect, .am_lock, .lane_hdr_strobe, .lane_hdr_ok,
    .fifo_flags, .lane_data, .lane_tag, .lane_am_strobe, .lane_bip_rx, .lane_bip_calc,
    .rx_byte, .rx_byte_valid, .rx_sof, .rx_eof, .ctrl_char_error, .ordered_data,
    .rx_pcs_ready, .local_fault_status, .rx_digital_reset, .fcs_error,
    .mii_decode_error, .bip_error, .irq
  );
  lane_link_partner far_u (
    .sys_clk, .link_on, .am_on, .hdr_bad, .bip_bad, .tag_map, .lane_clock_locked,
    .signal_detect, .am_lock, .lane_hdr_strobe, .lane_hdr_ok, .lane_data, .lane_tag,
    .lane_am_strobe, .lane_bip_rx, .lane_bip_calc
  );
  always #2.5 sys_clk = ~sys_clk;
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk_port(input string nm, input logic [NUM_LANES*LANE_W-1:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR register %h expected %h seen %h", a, exp, got);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk_reg(a, exp, reg_rd_data);
    @(posedge sys_clk);
    #1;
  endtask
  function automatic logic seen(input int w);
    case (w)
      0: return rx_pcs_ready;
      1: return !rx_pcs_ready;
      2: return |bip_error;
      default: return !rx_digital_reset;
    endcase
  endfunction
  task automatic wait_for(input int w);
    for (int n = 0; n < 500 && seen(w) !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (seen(w) !== 1'b1) begin
      chk_port("wait condition", 256'h1, 256'h0);
      complete_run();
    end
  endtask
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int k = 0; k < 8; k++) begin
      c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  function automatic logic [NUM_LANES*LANE_W-1:0] reorder(
    input logic [NUM_LANES*LANE_W-1:0] d, input logic [NUM_LANES*TAG_W-1:0] t);
    logic [NUM_LANES*LANE_W-1:0] o;
    o = '0;
    for (int p = 0; p < NUM_LANES; p++) begin
      o[t[p*TAG_W+:TAG_W]*LANE_W+:LANE_W] = d[p*LANE_W+:LANE_W];
    end
    return o;
  endfunction
  task automatic send_frame(input int len, input logic bad);
    logic [31:0] crc;
    crc = CRC_INIT;
    byte_q.delete();
    for (int i = 0; i < len; i++) begin
      byte_q.push_back(8'($urandom));
      crc = crc_byte(crc, byte_q[i]);
    end
    for (int i = 0; i < 4; i++) begin
      byte_q.push_back(~crc[i*8+:8]);
    end
    byte_q[2] ^= {7'h0, bad};
    @(posedge sys_clk);
    for (int i = 0; i < len + 4; i++) begin
      rx_byte <= byte_q[i];
      rx_byte_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_eof <= (i == len + 3);
      @(posedge sys_clk);
    end
    rx_byte_valid <= 1'b0;
    rx_eof <= 1'b0;
    #1;
    chk_port("fcs error", 256'(bad), fcs_error);
    chk_port("decode error", 256'h0, mii_decode_error);
  endtask
  initial begin
    seed_val = $urandom(91);
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk(ADDR_ALIGN, 32'h0);
    rd_chk(12'h000, 32'h0);
    rd_chk(ADDR_CLK_LOCK, 32'h0);
    link_on <= 1'b1;
    am_on <= 1'b1;
    wait_for(0);
    rd_chk(ADDR_ALIGN, 32'h1);
    rd_chk(ADDR_CLK_LOCK, 32'hf);
    wr(ADDR_FRM_CLR, 32'h1);
    wr(ADDR_FRM_CLR, 32'h0);
    rd_chk(ADDR_FRAME_ERR, 32'h0);
    wr(ADDR_IRQ_CLEAR, 32'h1f);
    rd_chk(ADDR_IRQ_STATUS, 32'h0);
    // Burst shorter than the loss window: lock must survive
    hdr_bad <= 4'h4;
    repeat (40) @(posedge sys_clk);
    hdr_bad <= 4'h0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk_port("ready", 256'h1, rx_pcs_ready);
    rd_chk(ADDR_FRAME_ERR, 32'h4);
    rd_chk(ADDR_FRAME_ERR, 32'h4);
    rd_chk(ADDR_IRQ_STATUS, 32'h1 << IRQ_FRM);
    chk_port("irq masked", 256'h0, irq);
    wr(ADDR_IRQ_ENABLE, 32'h1 << IRQ_FRM);
    chk_port("irq", 256'h1, irq);
    wr(ADDR_IRQ_CLEAR, 32'h1 << IRQ_FRM);
    rd_chk(ADDR_IRQ_STATUS, 32'h0);
    chk_port("irq cleared", 256'h0, irq);
    wr(ADDR_FRM_CLR, 32'h1);
    wr(ADDR_FRM_CLR, 32'h0);
    rd_chk(ADDR_FRAME_ERR, 32'h0);
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk) fifo_flags <= 16'($urandom);
      wr(ADDR_FLAG_SEL, 32'(s));
      rd_chk(ADDR_FLAG_VIEW, 32'(fifo_flags[s*4+:4]));
    end
    for (int r = 0; r < 8; r++) begin
      for (int p = 0; p < NUM_LANES; p++) begin
        tag_map[p*TAG_W+:TAG_W] <= TAG_W'(r[2] ? 3 - ((p + r) % 4) : (p + r) % 4);
      end
      repeat (2) @(posedge sys_clk);
      #1;
      snap_data = lane_data;
      snap_tag = lane_tag;
      @(posedge sys_clk);
      #1;
      chk_port("ordered data", reorder(snap_data, snap_tag), ordered_data);
    end
    for (int f = 0; f < 4; f++) begin
      send_frame(16 + f * 3, f[0]);
    end
    @(posedge sys_clk) ctrl_char_error <= 1'b1;
    @(posedge sys_clk);
    ctrl_char_error <= 1'b0;
    #1;
    chk_port("decode error", 256'h1, mii_decode_error);
    chk_port("fcs error", 256'h0, fcs_error);
    bip_bad <= 4'h2;
    wait_for(2);
    chk_port("bip error", 256'h2, bip_error);
    bip_bad <= 4'h0;
    wr(ADDR_CONFIG, 32'h1 << CFG_FAULT_EN);
    wr(ADDR_IRQ_ENABLE, 32'h1 << IRQ_LOS);
    link_on <= 1'b0;
    wait_for(1);
    chk_port("digital reset", 256'h1, rx_digital_reset);
    chk_port("local fault", 256'h1, local_fault_status);
    rd_chk(ADDR_ALIGN, 32'h0);
    chk_port("irq", 256'h1, irq);
    wait_for(3);
    link_on <= 1'b1;
    wait_for(0);
    am_on <= 1'b0;
    wait_for(1);
    chk_port("digital reset", 256'h0, rx_digital_reset);
    rd_chk(ADDR_ALIGN, 32'h0);
    complete_run();
  end
endmodule
